// ==== rtl/frp_pkg.sv ====
// Functional notes
// R1 - sda driven only changes while scl is low, except start and stop.
// R2 - one data bit taken per scl pulse, sampled while scl is high.
// R3 - sda falling while scl high is start; detected in any state.
// R4 - sda rising while scl high is stop; port returns to idle.
// R5 - after each received byte the port pulls sda low on clock nine.
// R6 - in reads sda is released after a byte; master ack sends next byte.
// R7 - master nack in a read stops transmission until the next stop or start.
// R8 - sda change during scl high mid-transfer abandons the transfer in progress.
// R9 - bytes are eight bits, msb first, each followed by an acknowledge bit.
// R10 - write: address with direction 0, ack, pointer, ack, acked data bytes.
// R11 - each acked write byte is stored at the pointer, then pointer increments.
// R12 - read: pointer written, then repeated start with direction 1 returns data.
// R13 - each master ack in a read increments pointer and sends that register.
// R14 - flash follow bit set: second emitter flash current copies first emitter.
// R15 - external strobe pulses should exceed one millisecond.
// R16 - reading a fault flag register clears it; enable low or soft reset too.
// R17 - only the fixed slave address is answered; others leave sda released.
// R18 - writes to read-only registers are acked but change nothing.
package frp_pkg;

	localparam logic [7:0] REG_PART_ID    = 8'h00;
	localparam logic [7:0] REG_OP_CTRL    = 8'h01;
	localparam logic [7:0] REG_DROOP      = 8'h02;
	localparam logic [7:0] REG_FIRST_FL   = 8'h03;
	localparam logic [7:0] REG_SECOND_FL  = 8'h04;
	localparam logic [7:0] REG_FIRST_ST   = 8'h05;
	localparam logic [7:0] REG_SECOND_ST  = 8'h06;
	localparam logic [7:0] REG_CONVERTER  = 8'h07;
	localparam logic [7:0] REG_RAMP       = 8'h08;
	localparam logic [7:0] REG_THERMISTOR = 8'h09;
	localparam logic [7:0] REG_FLAGS_P    = 8'h0a;
	localparam logic [7:0] REG_FLAGS_S    = 8'h0b;
	localparam logic [7:0] REG_REVISION   = 8'h0c;
	localparam logic [7:0] REG_LAST_FLASH = 8'h0d;

	localparam logic [7:0] RST_OP_CTRL    = 8'h80;
	localparam logic [7:0] RST_DROOP      = 8'h01;
	localparam logic [7:0] RST_FIRST_FL   = 8'hbf;
	localparam logic [7:0] RST_SECOND_FL  = 8'h3f;
	localparam logic [7:0] RST_FIRST_ST   = 8'hbf;
	localparam logic [7:0] RST_SECOND_ST  = 8'h3f;
	localparam logic [7:0] RST_CONVERTER  = 8'h09;
	localparam logic [7:0] RST_RAMP       = 8'h1a;
	localparam logic [7:0] RST_THERMISTOR = 8'h08;
	localparam logic [7:0] RST_FLAGS      = 8'h00;

	localparam logic [9:1][7:0] RST_CFG = {RST_THERMISTOR, RST_RAMP, RST_CONVERTER,
		RST_SECOND_ST, RST_FIRST_ST, RST_SECOND_FL, RST_FIRST_FL, RST_DROOP, RST_OP_CTRL};

	localparam int         BIT_FOLLOW    = 7;
	localparam int         BIT_SW_RESET  = 7;
	localparam logic [7:0] FLAGS_S_MASK  = 8'h1f;
	localparam logic [3:0] BIT_LAST      = 4'd7;
	localparam logic [3:0] BIT_ACK       = 4'd8;

	typedef enum logic [2:0] {
		FRP_IDLE,
		FRP_ADDR,
		FRP_PTR,
		FRP_WRITE,
		FRP_READ,
		FRP_WAIT
	} frp_mode_t;

	typedef struct packed {
		logic [7:0] thermistor_setup;
		logic [7:0] ramp_and_timeout_setup;
		logic [7:0] converter_setup;
		logic [7:0] second_emitter_steady_level;
		logic [7:0] first_emitter_steady_level;
		logic [7:0] second_emitter_flash_level;
		logic [7:0] first_emitter_flash_level;
		logic [7:0] input_droop_control;
		logic [7:0] operation_control;
	} frp_cfg_t;

endpackage

// ==== rtl/frp_port.sv ====
`timescale 1ns/1ns
module frp_port
	import frp_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR  = 7'h5a, // arbitrary value
	parameter logic [7:0] PART_ID     = 8'h5c, // arbitrary value
	parameter logic [7:0] PART_REV    = 8'h01  // arbitrary value
) (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       scl,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic       hardware_enable_pin,
	input  wire logic [7:0] fault_set_primary,
	input  wire logic [4:0] fault_set_secondary,
	input  wire logic [7:0] last_flash_code,
	output frp_cfg_t        cfg_out,
	output logic [6:0]      second_emitter_flash_eff,
	output logic [6:0]      second_emitter_steady_eff
);

	// link domain: one sample per scl rise, handed over with a toggle
	logic link_bit;
	logic link_tgl;

	always_ff @(posedge scl or negedge rst_n) begin
		if (!rst_n) begin
			link_bit <= 1'b0;
			link_tgl <= 1'b0;
		end else begin
			link_bit <= sda_in; // see R2
			link_tgl <= ~link_tgl;
		end
	end

	// core domain synchronisers
	logic [2:0] scl_s;
	logic [2:0] sda_s;
	logic [2:0] tgl_s;
	logic [1:0] hardware_enable_pin_s;
	logic [7:0] fp_s1, fp_s2;
	logic [4:0] fs_s1, fs_s2;
	logic [7:0] lf_s1, lf_s2;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_s  <= 3'h7;
			sda_s  <= 3'h7;
			tgl_s  <= 3'h0;
			hardware_enable_pin_s <= 2'h0;
			fp_s1  <= 8'h00;
			fp_s2  <= 8'h00;
			fs_s1  <= 5'h00;
			fs_s2  <= 5'h00;
			lf_s1  <= 8'h00;
			lf_s2  <= 8'h00;
		end else begin
			scl_s  <= {scl_s[1:0], scl};
			sda_s  <= {sda_s[1:0], sda_in};
			tgl_s  <= {tgl_s[1:0], link_tgl};
			hardware_enable_pin_s <= {hardware_enable_pin_s[0], hardware_enable_pin};
			fp_s1  <= fault_set_primary;
			fp_s2  <= fp_s1;
			fs_s1  <= fault_set_secondary;
			fs_s2  <= fs_s1;
			lf_s1  <= last_flash_code;
			lf_s2  <= lf_s1;
		end
	end

	// link bit stays put for a whole scl period, so reading it after the toggle is safe
	wire bit_evt    = tgl_s[2] ^ tgl_s[1];
	wire scl_high   = scl_s[1] & scl_s[2];
	wire start_evt  = scl_high & sda_s[2] & ~sda_s[1]; // see R3
	wire stop_evt   = scl_high & ~sda_s[2] & sda_s[1]; // see R4
	wire scl_fall   = scl_s[2] & ~scl_s[1];

	frp_mode_t   mode;
	logic [3:0]  cnt;
	logic [6:0]  shift;
	logic [7:0]  tx;
	logic [7:0]  ptr;
	logic        ack_due;
	logic [9:1][7:0] cfg_mem;
	logic [7:0]  flags_p;
	logic [7:0]  flags_s;
	logic        sw_rst;

	function automatic logic [7:0] read_reg(input logic [7:0] a, input logic [9:1][7:0] c,
		input logic [7:0] fp, input logic [7:0] fs, input logic [7:0] lf);
		logic [7:0] r;
		r = 8'h00;
		if (a == REG_PART_ID)
			r = PART_ID;
		else if (a >= REG_OP_CTRL && a <= REG_THERMISTOR)
			r = c[a[3:0]];
		else if (a == REG_FLAGS_P)
			r = fp;
		else if (a == REG_FLAGS_S)
			r = fs;
		else if (a == REG_REVISION)
			r = PART_REV;
		else if (a == REG_LAST_FLASH)
			r = lf;
		return r;
	endfunction

	wire active      = (mode != FRP_IDLE) && (mode != FRP_WAIT);
	wire byte_done   = bit_evt && active && (cnt == BIT_LAST);
	wire ack_slot    = bit_evt && active && (cnt == BIT_ACK);
	wire [7:0] full_byte = {shift, link_bit}; // see R9
	wire addr_hit    = full_byte[7:1] == SLAVE_ADDR;
	wire [7:0] ptr_inc = ptr + 8'h01;
	wire load_first  = byte_done && (mode == FRP_ADDR) && addr_hit && full_byte[0];
	wire load_next   = ack_slot && (mode == FRP_READ) && !link_bit;
	wire [7:0] load_addr = load_next ? ptr_inc : ptr;
	wire load_evt    = load_first | load_next;
	wire [7:0] load_data = read_reg(load_addr, cfg_mem, flags_p, flags_s, lf_s2);
	wire writable    = (ptr >= REG_OP_CTRL) && (ptr <= REG_THERMISTOR); // see R18
	wire wr_evt      = byte_done && (mode == FRP_WRITE) && writable;
	wire clr_p       = load_evt && (load_addr == REG_FLAGS_P); // see R16
	wire clr_s       = load_evt && (load_addr == REG_FLAGS_S); // see R16
	wire soft_clear  = sw_rst | ~hardware_enable_pin_s[1];
	wire tx_drive    = (mode == FRP_READ) && (cnt < BIT_ACK) && !tx[3'd7 - cnt[2:0]];

	// transfer engine
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode    <= FRP_IDLE;
			cnt     <= 4'd0;
			shift   <= 7'h00;
			tx      <= 8'h00;
			ptr     <= 8'h00;
			ack_due <= 1'b0;
		end else if (start_evt) begin // see R3
			mode    <= FRP_ADDR;
			cnt     <= 4'd0;
			ack_due <= 1'b0;
		end else if (stop_evt) begin // see R4
			mode    <= FRP_IDLE;
			cnt     <= 4'd0;
			ack_due <= 1'b0;
		end else if (bit_evt && active) begin
			// shifting on the eighth bit too leaves the direction bit in shift[0] for the ack slot
			if (cnt <= BIT_LAST)
				shift <= full_byte[6:0];
			if (load_evt)
				tx <= load_data;
			if (ack_slot)
				cnt <= 4'd0;
			else
				cnt <= cnt + 4'd1;
			if (ack_slot)
				ack_due <= 1'b0;
			if (byte_done) begin
				case (mode)
					FRP_ADDR: begin
						ack_due <= addr_hit; // see R17
						if (!addr_hit)
							mode <= FRP_WAIT; // see R17
					end
					FRP_PTR: begin
						ack_due <= 1'b1; // see R10
						ptr     <= full_byte;
					end
					FRP_WRITE: begin
						ack_due <= 1'b1; // see R5
						ptr     <= ptr_inc; // see R11
					end
					default: ack_due <= 1'b0;
				endcase
			end
			if (ack_slot) begin
				case (mode)
					FRP_ADDR:  mode <= shift[0] ? FRP_READ : FRP_PTR; // see R12
					FRP_PTR:   mode <= FRP_WRITE;
					FRP_WRITE: mode <= FRP_WRITE;
					FRP_READ: begin
						if (link_bit)
							mode <= FRP_WAIT; // see R7
						else
							ptr <= ptr_inc; // see R13
					end
					default:   mode <= FRP_IDLE;
				endcase
			end
		end
	end

	// sda only moves after scl has been seen low
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			sda_oe <= 1'b0;
		else if (start_evt || stop_evt)
			sda_oe <= 1'b0; // see R8
		else if (scl_fall)
			sda_oe <= ((cnt == BIT_ACK) && ack_due) || tx_drive; // see R1 R5 R6
	end

	// open drain: only ever pulls low
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			sda_out <= 1'b0;
		else
			sda_out <= 1'b0;
	end

	// soft reset bit never reads back as one
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			sw_rst <= 1'b0;
		else
			sw_rst <= wr_evt && (ptr == REG_CONVERTER) && full_byte[BIT_SW_RESET];
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			cfg_mem <= RST_CFG;
		else if (soft_clear)
			cfg_mem <= RST_CFG;
		else if (wr_evt)
			cfg_mem[ptr[3:0]] <= (ptr == REG_CONVERTER) ?
				(full_byte & ~(8'h01 << BIT_SW_RESET)) : full_byte; // see R11
	end

	// a fault arriving with the read clear is kept
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_p <= RST_FLAGS;
			flags_s <= RST_FLAGS;
		end else if (soft_clear) begin
			flags_p <= RST_FLAGS; // see R16
			flags_s <= RST_FLAGS; // see R16
		end else begin
			flags_p <= (clr_p ? RST_FLAGS : flags_p) | fp_s2; // see R16
			flags_s <= ((clr_s ? RST_FLAGS : flags_s) | {3'h0, fs_s2}) & FLAGS_S_MASK;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			second_emitter_flash_eff  <= RST_SECOND_FL[6:0];
			second_emitter_steady_eff <= RST_SECOND_ST[6:0];
		end else begin
			second_emitter_flash_eff  <= cfg_mem[REG_FIRST_FL[3:0]][BIT_FOLLOW] ?
				cfg_mem[REG_FIRST_FL[3:0]][6:0] : cfg_mem[REG_SECOND_FL[3:0]][6:0]; // see R14
			second_emitter_steady_eff <= cfg_mem[REG_FIRST_ST[3:0]][BIT_FOLLOW] ?
				cfg_mem[REG_FIRST_ST[3:0]][6:0] : cfg_mem[REG_SECOND_ST[3:0]][6:0];
		end
	end

	assign cfg_out = frp_cfg_t'(cfg_mem);

endmodule

// ==== testbench/frp_host_model.sv ====
`timescale 1ns/1ns
module frp_host_model (
	input  wire logic sda_oe,
	output logic      scl,
	output logic      sda_in
);
	localparam int Q = 625;
	// strobe pulses never reach this port, so their width is not driven here
	logic m_sda;
	// pull-up wire: low if either party pulls
	assign sda_in = m_sda & ~sda_oe;
	initial begin
		scl = 1'b1;
		m_sda = 1'b1;
	end
	task automatic bit_x(input logic b, output logic r);
		#Q m_sda = b;
		#Q scl = 1'b1;
		#Q r = sda_in;
		#Q scl = 1'b0;
	endtask
	task automatic start_c;
		#Q m_sda = 1'b1;
		#Q scl = 1'b1;
		#Q m_sda = 1'b0;
		#Q scl = 1'b0;
	endtask
	task automatic stop_c;
		#Q m_sda = 1'b0;
		#Q scl = 1'b1;
		#Q m_sda = 1'b1;
	endtask
	task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
		bit_x(ai, a);
	endtask
endmodule

// ==== testbench/frp_port_properties.sv ====
`timescale 1ns/1ns
module frp_port_properties
	import frp_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic       scl,
	input wire logic       sda_in,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic       hardware_enable_pin,
	input wire logic [7:0] fault_set_primary,
	input wire logic [4:0] fault_set_secondary,
	input wire logic [7:0] last_flash_code,
	input wire frp_cfg_t   cfg_out,
	input wire logic [6:0] second_emitter_flash_eff,
	input wire logic [6:0] second_emitter_steady_eff
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl)
		else $error("sda_oe moved while scl high");
	a_oe_after_fall: assert property ($rose(sda_oe) |-> !scl &&
		($past(scl, 2) || $past(scl, 3) || $past(scl, 4) || $past(scl, 5)))
		else $error("sda_oe rose away from an scl fall");
	a_out_low: assert property (sda_out == 1'b0)
		else $error("sda_out not low");
	a_start_quiet: assert property (scl && $past(scl) && $fell(sda_in) |-> (!sda_oe) [*8])
		else $error("sda_oe driven right after start");
	a_stop_quiet: assert property (scl && $past(scl) && $rose(sda_in) |-> (!sda_oe) [*8])
		else $error("sda_oe driven right after stop");
	a_flash_follow: assert property (second_emitter_flash_eff ==
		($past(cfg_out.first_emitter_flash_level[7]) ? $past(cfg_out.first_emitter_flash_level[6:0])
		: $past(cfg_out.second_emitter_flash_level[6:0])))
		else $error("second flash level wrong");
	a_steady_follow: assert property (second_emitter_steady_eff ==
		($past(cfg_out.first_emitter_steady_level[7]) ? $past(cfg_out.first_emitter_steady_level[6:0])
		: $past(cfg_out.second_emitter_steady_level[6:0])))
		else $error("second steady level wrong");
	a_hardware_enable_pin_default: assert property ((!hardware_enable_pin) [*5] |-> cfg_out == RST_CFG)
		else $error("config not at defaults while disabled");
	a_cfg_in_high: assert property ($changed(cfg_out) && hardware_enable_pin &&
		$past(hardware_enable_pin, 4) |-> scl)
		else $error("config changed outside a data bit");
	c_ack: cover property ($rose(sda_oe));
	c_hardware_enable_pin: cover property ((!hardware_enable_pin) [*5]);
	c_nofollow: cover property ($fell(cfg_out.first_emitter_flash_level[7]));
endmodule
bind frp_port frp_port_properties frp_port_properties_inst (.core_clk, .rst_n, .scl, .sda_in,
	.sda_out, .sda_oe, .hardware_enable_pin, .fault_set_primary, .fault_set_secondary,
	.last_flash_code, .cfg_out, .second_emitter_flash_eff, .second_emitter_steady_eff);

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
	import frp_pkg::*;
	localparam logic [6:0] ADDR = 7'h5a; // arbitrary value
	localparam logic [7:0] PID  = 8'h5c; // arbitrary value
	localparam logic [7:0] PREV = 8'h01; // arbitrary value
	logic       core_clk, rst_n, scl, sda_in, sda_out, sda_oe, hw_en, ack;
	logic [7:0] fp, lf, q;
	logic [4:0] fs;
	logic [6:0] fl_eff, st_eff;
	frp_cfg_t   cfg;
	int         fail_count, n_checks;
	int         mdl[14];
	frp_port #(.SLAVE_ADDR(ADDR), .PART_ID(PID), .PART_REV(PREV)) frp_port_inst (.core_clk,
		.rst_n, .scl, .sda_in, .sda_out, .sda_oe, .hardware_enable_pin(hw_en),
		.fault_set_primary(fp), .fault_set_secondary(fs), .last_flash_code(lf),
		.cfg_out(cfg), .second_emitter_flash_eff(fl_eff), .second_emitter_steady_eff(st_eff));
	frp_host_model frp_host_model_inst (.sda_oe, .scl, .sda_in);
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic put(input logic [7:0] d, input logic ea);
		frp_host_model_inst.xfer(d, 1'b1, q, ack);
		chk("ack", {7'h00, ack}, {7'h00, ea});
	endtask
	task automatic hdr(input logic [7:0] p);
		frp_host_model_inst.start_c;
		put({ADDR, 1'b0}, 1'b0);
		put(p, 1'b0);
	endtask
	task automatic wr(input int p, input int n);
		logic [7:0] d;
		hdr(8'(p));
		for (int i = p; i < p + n; i++) begin
			d = 8'($urandom);
			if (i == 7) d[7] = 1'b0;
			put(d, 1'b0);
			if (i > 0 && i < 10) mdl[i] = d;
		end
		frp_host_model_inst.stop_c;
	endtask
	task automatic rd(input int p, input int n);
		hdr(8'(p));
		frp_host_model_inst.start_c;
		put({ADDR, 1'b1}, 1'b0);
		for (int i = p; i < p + n; i++) begin
			frp_host_model_inst.xfer(8'hff, i == p + n - 1, q, ack);
			chk("rdata", q, (i < 14) ? 8'(mdl[i]) : 8'h00);
			if (i == 10 || i == 11) mdl[i] = 0;
		end
		frp_host_model_inst.stop_c;
	endtask
	task automatic chk_cfg;
		for (int i = 1; i < 10; i++) chk("cfg", cfg[8*i-8 +: 8], 8'(mdl[i]));
		chk("flash_eff", {1'b0, fl_eff}, 8'((mdl[3][7] ? mdl[3] : mdl[4]) & 'h7f));
		chk("steady_eff", {1'b0, st_eff}, 8'((mdl[5][7] ? mdl[5] : mdl[6]) & 'h7f));
	endtask
	task automatic fault;
		@(posedge core_clk);
		#2 fp = 8'($urandom);
		fs = 5'($urandom);
		mdl[10] |= fp;
		mdl[11] |= fs;
		repeat (4) @(posedge core_clk);
		#2 fp = 8'h00;
		fs = 5'h00;
	endtask
	task automatic set_defaults;
		for (int i = 1; i < 12; i++) mdl[i] = (i < 10) ? int'(RST_CFG[i]) : 0;
	endtask
	task automatic hw_pulse;
		@(posedge core_clk);
		#2 hw_en = 1'b0;
		repeat (8) @(posedge core_clk);
		#2 hw_en = 1'b1;
		set_defaults;
		repeat (4) @(posedge core_clk);
		// keeps later host edges off the core clock edges
		#2;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	initial begin
		#4500000 fail_count++;
		end_sim;
	end
	initial begin
		rst_n = 1'b0;
		hw_en = 1'b0;
		fp = 8'h00;
		fs = 5'h00;
		void'($urandom(2826));
		lf = 8'($urandom);
		mdl[0] = PID;
		mdl[12] = PREV;
		mdl[13] = lf;
		repeat (6) @(posedge core_clk);
		#2 rst_n = 1'b1;
		hw_pulse;
		rd(0, 14);
		chk_cfg;
		wr(1, 14);
		chk_cfg;
		rd(0, 15);
		hdr(8'h00);
		frp_host_model_inst.start_c;
		put({ADDR ^ 7'h01, 1'b0}, 1'b1);
		put(8'h03, 1'b1);
		frp_host_model_inst.stop_c;
		chk_cfg;
		fault;
		rd(9, 3);
		rd(10, 2);
		hdr(8'h05);
		frp_host_model_inst.bit_x(1'b0, ack);
		frp_host_model_inst.bit_x(1'b1, ack);
		frp_host_model_inst.stop_c;
		rd(5, 1);
		repeat (4) begin
			wr(3, 4);
			chk_cfg;
		end
		fault;
		hdr(8'h07);
		put(8'h80, 1'b0);
		frp_host_model_inst.stop_c;
		set_defaults;
		chk_cfg;
		rd(10, 2);
		fault;
		hw_pulse;
		chk_cfg;
		rd(10, 2);
		end_sim;
	end
endmodule
